// ==== src/rpp_rmii_pins.sv ====
// Purpose: mac-facing rmii pins, reset straps and link led
// Assumes: pins synchronous to core_clk; pulls resolved at the pad
// Notes:   strap pins double as receive and led outputs after reset
`timescale 1ns/1ps
`include "rpp_consts.svh"

// What this block does
// - receive data leaves two bits at once
// - receive error flags errored frames
// - carrier/valid high while medium busy
// - 10M: data low until start delimiter
// - no transmit echo in 10M half duplex
// - straps caught at every reset, held
// - three mode straps form mode code
// - address strap gives management address bit
// - led on with link, blinks on activity
// - regulator off when strap latched high
// - regulator on when strap low/floating
// - mode pins pull up, address down
module rpp_rmii_pins
  import rpp_pkg::*;
#(
  parameter int BLINK_CYCLES = `RPP_BLINK_CYCLES
) (
  input  wire logic            core_clk,
  input  wire logic            reset,
  input  wire logic [1:0]      txd,
  input  wire logic            txEn,
  output logic [1:0]           coreTxDibit,
  output logic                 coreTxValid,
  input  wire rpp_rx_line_type lineRx,
  input  wire logic            linkUp,
  input  wire logic            linkActivity,
  input  wire logic [3:0]      sharedPinIn,
  output logic [3:0]           sharedPinOut,
  output logic [3:0]           sharedPinOe,
  output logic [3:0]           sharedPullUp,
  output logic [3:0]           sharedPullDown,
  input  wire logic            ledPinIn,
  output logic                 ledPinOut,
  output logic                 ledPinOe,
  output logic                 ledPullDown,
  output rpp_strap_type        strapCfg,
  output logic                 regulatorEnable
);

  // ---------------- transmit side ----------------
  logic [1:0] next_coreTxDibit; // dibit toward the line
  logic       next_coreTxValid; // its qualifier

  // data only means something while enable is high
  always_comb begin
    next_coreTxValid = txEn;
    next_coreTxDibit = txEn ? txd : 2'h0;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      coreTxDibit <= 2'h0;
      coreTxValid <= 1'b0;
    end else begin
      coreTxDibit <= next_coreTxDibit;
      coreTxValid <= next_coreTxValid;
    end
  end

  // ---------------- receive side ----------------
  rpp_rx_state_type state;       // delimiter hunt state
  rpp_rx_state_type next_state;
  logic [7:0]       sfdShift;    // last four dibits, lsb first
  logic [7:0]       next_sfdShift;
  logic [1:0]       rxd;         // receive data pins
  logic [1:0]       next_rxd;
  logic             crsDv;       // carrier sense / data valid
  logic             next_crsDv;
  logic             rxErr;       // receive error
  logic             next_rxErr;
  logic             loopBlock;   // own transmit data in 10M half duplex
  logic             take;        // a dibit worth passing on

  // echo of our own transmit data in 10M half duplex is dropped, never shown to the mac
  assign loopBlock = lineRx.is10 & ~lineRx.fullDuplex & lineRx.echo;
  assign take      = lineRx.valid & ~loopBlock;

  // 100M passes data at once; 10M hides preamble and delimiter
  always_comb begin
    next_state    = state;
    next_sfdShift = sfdShift;
    next_rxd      = rxd;
    next_crsDv    = lineRx.active;
    next_rxErr    = lineRx.active & lineRx.error;
    unique case (state)
      RPP_IDLE: begin
        next_rxd      = 2'h0;
        next_sfdShift = 8'h00;
        if (lineRx.active) begin
          if (lineRx.is10) begin
            next_state = RPP_HUNT;
          end else begin
            next_state = RPP_PASS;
            if (take) begin
              next_rxd = lineRx.dibit;
            end
          end
        end
      end
      RPP_HUNT: begin
        next_rxd = 2'h0;
        if (take) begin
          next_sfdShift = {lineRx.dibit, sfdShift[7:2]};
          // the delimiter itself is still held low
          if (next_sfdShift == `RPP_SFD_BYTE) begin
            next_state = RPP_PASS;
          end
        end
      end
      RPP_PASS: begin
        if (take) begin
          next_rxd = lineRx.dibit;
        end
      end
      default: begin
        next_state = RPP_IDLE; // illegal code recovers
      end
    endcase
    // end of carrier ends the frame in every state
    if (!lineRx.active) begin
      next_state = RPP_IDLE;
      next_rxd   = 2'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state    <= RPP_IDLE;
      sfdShift <= 8'h00;
      rxd      <= 2'h0;
      crsDv    <= 1'b0;
      rxErr    <= 1'b0;
    end else begin
      state    <= next_state;
      sfdShift <= next_sfdShift;
      rxd      <= next_rxd;
      crsDv    <= next_crsDv;
      rxErr    <= next_rxErr;
    end
  end

  // ---------------- straps and pin direction ----------------
  rpp_strap_type next_strapCfg; // caught configuration
  logic          pinOe;         // receive pins driven
  logic          next_pinOe;

  // sampling goes on every cycle of reset, so the level at release
  // sticks; the pins are not driven then, so the strap is seen clean
  always_comb begin
    next_strapCfg = strapCfg;
    if (reset) begin
      next_strapCfg.opMode = {sharedPinIn[`RPP_PIN_CRS],
                              sharedPinIn[`RPP_PIN_RXD1],
                              sharedPinIn[`RPP_PIN_RXD0]};
      next_strapCfg.mgmtAddr = sharedPinIn[`RPP_PIN_ERR];
      next_strapCfg.regulator_disable_strap   = ledPinIn;
    end
    next_pinOe = ~reset;
  end

  // no reset branch: reset itself is the capture window
  always_ff @(posedge core_clk) begin
    strapCfg <= next_strapCfg;
    pinOe    <= next_pinOe;
  end

  assign regulatorEnable = ~strapCfg.regulator_disable_strap;

  // pad pulls as constant vectors so each pin takes exactly one bit;
  // the pulls stay on while driving, since the driver overpowers them
  localparam logic [3:0] PULL_UP_BITS   = `RPP_PULL_UP_MASK;   // modes up
  localparam logic [3:0] PULL_DOWN_BITS = `RPP_PULL_DOWN_MASK; // address down

  // the outputs are low during reset since their flops reset to zero
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      assign sharedPinOe[gi]    = pinOe;
      assign sharedPullUp[gi]   = PULL_UP_BITS[gi];
      assign sharedPullDown[gi] = PULL_DOWN_BITS[gi];
    end
  endgenerate
  assign sharedPinOut = {rxErr, crsDv, rxd};
  assign ledPullDown  = 1'b1; // regulator strap floats low

  // ---------------- link / activity led ----------------
  logic        linkSeen;       // registered link level
  logic        blinkBusy;      // blink cycle in progress
  logic        next_blinkBusy;
  logic        blinkPhase;     // high while led is dark
  logic        next_blinkPhase;
  logic [31:0] blinkCnt;       // half period counter
  logic [31:0] next_blinkCnt;
  logic        ledActive;      // led lit, before polarity

  // one blink is a dark half then a lit half; activity during a
  // blink is folded into it, so a busy link blinks steadily
  always_comb begin
    next_blinkBusy  = blinkBusy;
    next_blinkPhase = blinkPhase;
    next_blinkCnt   = blinkCnt;
    if (!linkUp) begin
      next_blinkBusy  = 1'b0;
      next_blinkPhase = 1'b0;
      next_blinkCnt   = 32'h0;
    end else if (!blinkBusy) begin
      if (linkActivity) begin
        next_blinkBusy  = 1'b1;
        next_blinkPhase = 1'b1;
        next_blinkCnt   = 32'h0;
      end
    end else if (blinkCnt == 32'(BLINK_CYCLES - 1)) begin
      next_blinkCnt   = 32'h0;
      next_blinkPhase = 1'b0;
      next_blinkBusy  = blinkPhase; // second half ends it
    end else begin
      next_blinkCnt = blinkCnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      linkSeen   <= 1'b0;
      blinkBusy  <= 1'b0;
      blinkPhase <= 1'b0;
      blinkCnt   <= 32'h0;
    end else begin
      linkSeen   <= linkUp;
      blinkBusy  <= next_blinkBusy;
      blinkPhase <= next_blinkPhase;
      blinkCnt   <= next_blinkCnt;
    end
  end

  // a high regulator strap holds the pin up, so the led turns active low
  assign ledActive = linkSeen & ~blinkPhase;
  assign ledPinOut = pinOe & (ledActive ^ strapCfg.regulator_disable_strap);
  assign ledPinOe  = pinOe;

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence sfdLastDibit;
    state == RPP_HUNT && take && lineRx.active &&
      {lineRx.dibit, sfdShift[7:2]} == `RPP_SFD_BYTE;
  endsequence

  sequence releaseEdge;
    reset ##1 !reset;
  endsequence

  AST_TX_QUAL: assert property (txEn |=> coreTxValid && coreTxDibit == $past(txd))
    else $error("transmit dibit not passed with enable");
  // a dropped enable must not leak a stale dibit toward the line
  AST_TX_IDLE: assert property (!txEn |=> !coreTxValid && coreTxDibit == 2'h0)
    else $error("transmit dibit passed without enable");
  // a quiet medium leaves carrier sense and both receive data pins low the cycle after
  AST_IDLE_LOW: assert property (!lineRx.active |=> !crsDv && rxd == 2'h0)
    else $error("receive pins not idle after carrier loss");
  AST_CRS_BUSY: assert property (lineRx.active |=> crsDv && sharedPinOut[2])
    else $error("carrier sense low on busy medium");
  AST_ERR_FLAG: assert property (lineRx.active && lineRx.error |=> rxErr)
    else $error("receive error not flagged");
  AST_HUNT_LOW: assert property (state == RPP_IDLE && lineRx.active && lineRx.is10
    |=> rxd == 2'h0 && state == RPP_HUNT)
    else $error("10M data not held low before delimiter");
  AST_SFD_OPEN: assert property (sfdLastDibit |=> state == RPP_PASS && rxd == 2'h0)
    else $error("delimiter did not open the frame");
  AST_PASS_DATA: assert property (state == RPP_PASS && lineRx.active && take
    |=> rxd == $past(lineRx.dibit))
    else $error("receive dibit not delivered");
  AST_NO_ECHO: assert property (state == RPP_PASS && lineRx.active && loopBlock
    |=> $stable(rxd))
    else $error("transmit echo reached receive pins");
  AST_STRAP_HOLD: assert property (!$past(reset) |-> $stable(strapCfg))
    else $error("strap configuration changed outside reset");
  // the copy seen at release comes from the pins at the last reset edge
  AST_MODE_CODE: assert property (disable iff (1'b0) releaseEdge
    |-> strapCfg.opMode == $past(sharedPinIn[2:0])
     && strapCfg.mgmtAddr == $past(sharedPinIn[3]))
    else $error("mode or address strap not caught at release");
  AST_REG_EN: assert property (disable iff (1'b0) releaseEdge
    |-> regulatorEnable == !$past(ledPinIn))
    else $error("regulator enable does not follow strap");
  AST_PIN_DIR: assert property (disable iff (1'b0) releaseEdge
    |-> sharedPinOe == 4'h0 ##1 sharedPinOe == 4'hf)
    else $error("shared pins driven in reset or not after");
  // only one cycle: link may come back at once and light the led again
  AST_LED_LINK: assert property (!linkUp |=> !ledActive)
    else $error("led lit without link");

endmodule

// ==== common/rpp_consts.svh ====
// Purpose: constants of the rmii pin and strap block
// Assumes: core clock of 40 MHz
// Notes:   definitions only
`ifndef RPP_CONSTS_SVH
`define RPP_CONSTS_SVH
`define RPP_CLK_PERIOD_NS 25
// blink half period, plain default
`define RPP_BLINK_HALF_US 50000
`define RPP_BLINK_CYCLES ((`RPP_BLINK_HALF_US * 1000) / `RPP_CLK_PERIOD_NS)
// start-of-frame byte 10101011 as sent, packed lsb-first
`define RPP_SFD_BYTE 8'hd5
// shared pin positions
`define RPP_PIN_RXD0 0
`define RPP_PIN_RXD1 1
`define RPP_PIN_CRS  2
`define RPP_PIN_ERR  3
// pull of each shared pin while it floats: modes up, address down
`define RPP_PULL_UP_MASK   4'h7
`define RPP_PULL_DOWN_MASK 4'h8
`endif

// ==== common/rpp_pkg.sv ====
// Purpose: types of the rmii pin and strap block
// Assumes: nothing
// Notes:   constants live in rpp_consts.svh
package rpp_pkg;
  // receive stream from the line side
  typedef struct packed {
    logic       active;     // medium not idle
    logic       is10;       // 10 Mb/s operation
    logic       fullDuplex; // duplex of the link
    logic       valid;      // dibit present this cycle
    logic [1:0] dibit;      // {bit1, bit0}
    logic       error;      // error seen in frame
    logic       echo;       // dibit is own transmit data
  } rpp_rx_line_type;
  // configuration caught at reset
  typedef struct packed {
    logic [2:0] opMode;   // default operating mode
    logic       mgmtAddr; // management address bit 0
    logic       regulator_disable_strap;   // regulator disable strap
  } rpp_strap_type;
  typedef enum logic [1:0] {
    RPP_IDLE = 2'b00,
    RPP_HUNT = 2'b01,
    RPP_PASS = 2'b10
  } rpp_rx_state_type;
endpackage

// ==== test/rpp_mac_model.sv ====
// Purpose: mac side model that drives the rmii transmit pins
// Assumes: one dibit per core_clk cycle, requests launched on the rising edge
// Notes:   released data lines toggle every cycle, first to the inverse of the last dibit
`timescale 1ns/1ps
module rpp_mac_model (
  input  wire logic       core_clk,
  input  wire logic       sendGo,
  input  wire logic [1:0] sendDibit,
  output logic [1:0]      txd  = 2'h0, // zero at start, then toggling until the first frame
  output logic            txEn = 1'h0
);
  // enable only while a dibit is really presented
  always @(posedge core_clk) begin
    txEn <= sendGo;
    // idle data toggles so a stale dibit never passes for a real one
    txd  <= sendGo ? sendDibit : ~txd;
  end
endmodule

// ==== test/rpp_rmii_pins_tb.sv ====
// Purpose: self-checking bench of the rmii pins, straps and led
// Assumes: blink half period shortened to 4 cycles
// Notes:   floating pins are resolved here from the pull outputs
`timescale 1ns/1ps
module rpp_rmii_pins_tb
  import rpp_pkg::*;
;
  logic            core_clk = 1'h0; // 40 MHz
  logic            reset    = 1'h1; // held 20 cycles
  logic [1:0]      txd;             // from mac model
  logic            txEn;
  logic            sendGo    = 1'h0;
  logic [1:0]      sendDibit = 2'h0;
  logic [1:0]      coreTxDibit;
  logic            coreTxValid;
  rpp_rx_line_type lineRx       = '0;
  logic            linkUp       = 1'h0;
  logic            linkActivity = 1'h0;
  logic [3:0]      sharedPinIn, sharedPinOut, sharedPinOe, sharedPullUp, sharedPullDown;
  logic            ledPinIn, ledPinOut, ledPinOe, ledPullDown;
  rpp_strap_type   strapCfg;
  logic            regulatorEnable;
  logic [3:0]      strapDrv    = 4'h0; // straps float at first
  logic [3:0]      strapVal    = 4'h0;
  logic            ledStrapDrv = 1'h0;
  logic            ledStrapVal = 1'h0;
  logic [7:0]      dark;
  int              badCount = 0;
  int              nTests   = 0;
  // receive stimulus, 100M frame then 10M half duplex frame with an echo
  logic [7:0]      rxSeq [12] = '{8'h98, 8'h96, 8'h00, 8'hd4, 8'hd4, 8'hd4,
                                  8'hd4, 8'hdc, 8'hd8, 8'hd5, 8'h00, 8'h00};
  // pins {err, crs, rxd1, rxd0} seen as each entry goes on, one cycle after the entry before
  logic [3:0]      rxExp [12] = '{4'h0, 4'h6, 4'hd, 4'h0, 4'h4, 4'h4,
                                  4'h4, 4'h4, 4'h4, 4'h6, 4'h6, 4'h0};

  always #12.5 core_clk = ~core_clk;

  // pad resolution: driver, then strap resistor, then internal pull
  assign sharedPinIn = (sharedPinOe & sharedPinOut) |
                       (~sharedPinOe & ((strapDrv & strapVal) | (~strapDrv & sharedPullUp)));
  assign ledPinIn    = ledPinOe ? ledPinOut : (ledStrapDrv ? ledStrapVal : !ledPullDown);

  rpp_mac_model rpp_mac_model_inst (.core_clk(core_clk), .sendGo(sendGo),
                                    .sendDibit(sendDibit), .txd(txd), .txEn(txEn));

  rpp_rmii_pins #(.BLINK_CYCLES(4)) rpp_rmii_pins_inst (
    .core_clk(core_clk), .reset(reset), .txd(txd), .txEn(txEn),
    .coreTxDibit(coreTxDibit), .coreTxValid(coreTxValid), .lineRx(lineRx),
    .linkUp(linkUp), .linkActivity(linkActivity), .sharedPinIn(sharedPinIn),
    .sharedPinOut(sharedPinOut), .sharedPinOe(sharedPinOe), .sharedPullUp(sharedPullUp),
    .sharedPullDown(sharedPullDown), .ledPinIn(ledPinIn), .ledPinOut(ledPinOut),
    .ledPinOe(ledPinOe), .ledPullDown(ledPullDown), .strapCfg(strapCfg),
    .regulatorEnable(regulatorEnable));

  // one comparison, counted; four-state equality so unknowns fail
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // single exit point of the run
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog, well beyond the 70 or so cycles the tests need
  initial begin
    repeat (2000) @(posedge core_clk);
    badCount++;
    wrapUp();
  end

  initial begin
    // first reset with every strap floating
    repeat (19) @(posedge core_clk);
    #1 chk({4'h0, sharedPinOe}, 8'h00);
    @(posedge core_clk) reset <= 1'h0;
    @(posedge core_clk);
    #1 chk({4'h0, sharedPinOe}, 8'h0f);
    chk({3'h0, strapCfg}, 8'h1c);
    chk({7'h0, regulatorEnable}, 8'h01);
    chk({sharedPullUp, sharedPullDown}, 8'h78);
    chk({6'h0, ledPinOe, ledPullDown}, 8'h03);
    // back to back transmit dibits, then the enable drops
    @(posedge core_clk) begin sendGo <= 1'h1; sendDibit <= 2'h1; end
    @(posedge core_clk) sendDibit <= 2'h2;
    @(posedge core_clk) sendGo <= 1'h0;
    #1 chk({5'h0, coreTxValid, coreTxDibit}, 8'h05);
    @(posedge core_clk);
    #1 chk({5'h0, coreTxValid, coreTxDibit}, 8'h06);
    @(posedge core_clk);
    #1 chk({5'h0, coreTxValid, coreTxDibit}, 8'h00);
    // receive frames, one entry per cycle
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk) lineRx <= rpp_rx_line_type'(rxSeq[i]);
      #1 chk({4'h0, sharedPinOut}, {4'h0, rxExp[i]});
    end
    // led lit with link, one dark span of the blink on activity
    @(posedge core_clk) linkUp <= 1'h1;
    repeat (3) @(posedge core_clk);
    #1 chk({7'h0, ledPinOut}, 8'h01);
    @(posedge core_clk) linkActivity <= 1'h1;
    dark = 8'h00;
    repeat (16) begin
      @(posedge core_clk) linkActivity <= 1'h0;
      #1 dark = dark + {7'h0, ~ledPinOut};
    end
    chk(dark, 8'h04);
    @(posedge core_clk) linkUp <= 1'h0;
    repeat (3) @(posedge core_clk);
    #1 chk({7'h0, ledPinOut}, 8'h00);
    // second reset with driven straps, regulator strap high
    @(posedge core_clk) begin
      strapDrv    <= 4'hf;
      strapVal    <= 4'ha;
      ledStrapDrv <= 1'h1;
      ledStrapVal <= 1'h1;
      reset       <= 1'h1;
    end
    @(posedge core_clk);
    @(posedge core_clk) reset <= 1'h0;
    @(posedge core_clk);
    #1 chk({3'h0, strapCfg}, 8'h0b);
    chk({7'h0, regulatorEnable}, 8'h00);
    // straps move after reset; the latched copy must not
    @(posedge core_clk) begin strapVal <= 4'h5; ledStrapVal <= 1'h0; end
    repeat (2) @(posedge core_clk);
    #1 chk({3'h0, strapCfg}, 8'h0b);
    chk({7'h0, ledPinOut}, 8'h01);
    wrapUp();
  end
endmodule
